// ==== hdl/rmo_pkg.sv ====
// Package with constants and types for the remote output register block.
package rmo_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned FSEL_W = 8;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [FSEL_W-1:0] FSEL_REM_POS = 8'h60;
  localparam logic [FSEL_W-1:0] FSEL_REM_NEG = 8'hc4;
  localparam logic [MODE_W-1:0] MODE_CLR_CLR = 4'h0;
  localparam logic [MODE_W-1:0] MODE_KEEP_CLR = 4'h1;
  localparam logic [MODE_W-1:0] MODE_CLR_KEEP = 4'ha;
  localparam logic [MODE_W-1:0] MODE_KEEP_KEEP = 4'hb;
  localparam int unsigned TERM_BIT = 0;
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_FSEL = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [DATA_W-1:0] wdata;
  } rmo_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
  } rmo_rsp_type;
endpackage

// ==== hdl/rmo_sync.sv ====
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/100ps
module rmo_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  logic s1_nxt;
  logic s2_nxt;

  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;
endmodule

// ==== hdl/rmo_remote_output.sv ====
// Remote output data register driving the general output terminal.
// What this block does
// - The general output terminal follows the remote output data register that the host writes.
// - The remote function reaches the terminal only when the function select is 96 or 196.
// - A data bit of 1 turns the terminal on and 0 off, inverted under negative polarity.
// - In modes 0 and 10 a power-on reset clears the data and returns the terminal to its default.
// - In modes 1 and 11 the data is saved to nonvolatile memory at power-off and restored.
// - A drive reset never writes the data to nonvolatile memory.
// - Modes 10 and 11 hold the data through a drive reset; modes 0 and 1 clear it.
// - A terminal not assigned the remote function ignores the data bit and follows its function.
// - The data register accepts 0 to 4095 and starts at zero.
// - The data register is writable in any operating mode regardless of write protect.
// - Mode and data settings are reachable only while the user-group read select is 0.
`timescale 1ns/100ps
module rmo_remote_output
  import rmo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input rmo_pkg::rmo_req_type req,
  output rmo_pkg::rmo_rsp_type rsp,
  input wire logic drive_reset,
  input wire logic power_fail,
  input wire logic write_protect,
  input wire logic [15:0] user_group_read_select,
  input wire logic [rmo_pkg::DATA_W-1:0] nvm_data,
  input wire logic nvm_valid,
  input wire logic assigned_function_out,
  output logic nvm_save,
  output logic [rmo_pkg::DATA_W-1:0] nvm_save_data,
  output logic general_output_terminal
);
  import rmo_pkg::*;

  logic power_fail_s;
  logic drive_reset_s;
  logic assigned_s;

  rmo_sync u_sync_pf (.clk(clk), .rst_n(rst_n), .d(power_fail), .q(power_fail_s));
  rmo_sync u_sync_dr (.clk(clk), .rst_n(rst_n), .d(drive_reset), .q(drive_reset_s));
  rmo_sync u_sync_fn (.clk(clk), .rst_n(rst_n), .d(assigned_function_out), .q(assigned_s));

  logic [DATA_W-1:0] data_r, data_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [FSEL_W-1:0] fsel_r, fsel_nxt;
  logic restored_r, restored_nxt;
  logic pf_prev_r, pf_prev_nxt;
  logic save_r, save_nxt;
  logic [DATA_W-1:0] save_data_r, save_data_nxt;
  logic term_r, term_nxt;
  rmo_rsp_type rsp_r, rsp_nxt;
  logic retain_power;
  logic retain_reset;
  logic group_open;
  logic rem_pos;
  logic rem_neg;

  always_comb begin
    retain_power = (mode_r == MODE_KEEP_CLR) || (mode_r == MODE_KEEP_KEEP);
    retain_reset = (mode_r == MODE_CLR_KEEP) || (mode_r == MODE_KEEP_KEEP);
    group_open = (user_group_read_select == 16'h0000);
    rem_pos = (fsel_r == FSEL_REM_POS);
    rem_neg = (fsel_r == FSEL_REM_NEG);
  end

  always_comb begin
    data_nxt = data_r;
    mode_nxt = mode_r;
    fsel_nxt = fsel_r;
    restored_nxt = restored_r;
    pf_prev_nxt = power_fail_s;
    save_nxt = 1'b0;
    save_data_nxt = save_data_r;
    rsp_nxt = '0;
    // Restore once after power-on. The mode register itself is cleared by power-on reset, so
    // the store's valid flag decides: it only holds data saved under a retention mode.
    if (!restored_r) begin
      restored_nxt = 1'b1;
      if (nvm_valid) begin
        data_nxt = nvm_data;
      end
    end
    // Power-off: save only in a retention mode; a drive reset never saves.
    if (power_fail_s && !pf_prev_r) begin
      if (retain_power) begin
        save_nxt = 1'b1;
        save_data_nxt = data_r;
      end
    end
    if (req.wr || req.rd) begin
      rsp_nxt.ack = 1'b1;
      case (req.sel)
        SEL_MODE: begin
          if (!group_open) begin
            rsp_nxt.err = 1'b1;
          end else if (req.wr && write_protect) begin
            rsp_nxt.err = 1'b1;
          end else if (req.wr) begin
            mode_nxt = req.wdata[MODE_W-1:0];
          end
          rsp_nxt.rdata = {{(DATA_W-MODE_W){1'b0}}, mode_r};
        end
        SEL_DATA: begin
          if (!group_open) begin
            rsp_nxt.err = 1'b1;
          end else if (req.wr) begin
            data_nxt = req.wdata;
          end
          rsp_nxt.rdata = data_r;
        end
        SEL_FSEL: begin
          if (req.wr && write_protect) begin
            rsp_nxt.err = 1'b1;
          end else if (req.wr) begin
            fsel_nxt = req.wdata[FSEL_W-1:0];
          end
          rsp_nxt.rdata = {{(DATA_W-FSEL_W){1'b0}}, fsel_r};
        end
        default: begin
          rsp_nxt.err = 1'b1;
        end
      endcase
    end
    if (drive_reset_s && !retain_reset) begin
      data_nxt = DATA_RESET;
    end
    if (rem_pos) begin
      term_nxt = data_r[TERM_BIT];
    end else if (rem_neg) begin
      term_nxt = ~data_r[TERM_BIT];
    end else begin
      term_nxt = assigned_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= DATA_RESET;
      mode_r <= MODE_RESET;
      fsel_r <= 8'h00;
      restored_r <= 1'b0;
      pf_prev_r <= 1'b0;
      save_r <= 1'b0;
      save_data_r <= DATA_RESET;
      term_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      data_r <= data_nxt;
      mode_r <= mode_nxt;
      fsel_r <= fsel_nxt;
      restored_r <= restored_nxt;
      pf_prev_r <= pf_prev_nxt;
      save_r <= save_nxt;
      save_data_r <= save_data_nxt;
      term_r <= term_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign rsp = rsp_r;
  assign nvm_save = save_r;
  assign nvm_save_data = save_data_r;
  assign general_output_terminal = term_r;
endmodule

// ==== dv/rmo_remote_output_assertions.sv ====
// Checker for the remote output register block.
`timescale 1ns/100ps
module rmo_remote_output_assertions
  import rmo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input rmo_pkg::rmo_req_type req,
  input rmo_pkg::rmo_rsp_type rsp,
  input wire logic power_fail,
  input wire logic [15:0] user_group_read_select,
  input wire logic nvm_save
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_calm; !power_fail [*6]; endsequence
  sequence s_grp; user_group_read_select != 16'h0 && req.sel != SEL_FSEL; endsequence
  property p_ack; req.wr || req.rd |=> rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !(req.wr || req.rd) |=> !rsp.ack; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_eack; rsp.err |-> rsp.ack; endproperty
  a_eack: assert property (p_eack) else $error("err alone");
  property p_grp; (req.wr || req.rd) ##0 s_grp |=> rsp.err; endproperty
  a_grp: assert property (p_grp) else $error("group not refused");
  property p_data; req.wr && req.sel == SEL_DATA && user_group_read_select == 16'h0 |=> !rsp.err; endproperty
  a_data: assert property (p_data) else $error("data write refused");
  property p_rdd; req.rd && req.sel == SEL_DATA && user_group_read_select == 16'h0 |=> !rsp.err; endproperty
  a_rdd: assert property (p_rdd) else $error("data read refused");
  property p_save; nvm_save |-> $past(power_fail, 2); endproperty
  a_save: assert property (p_save) else $error("save without power fail");
  property p_nosave; s_calm |-> !nvm_save; endproperty
  a_nosave: assert property (p_nosave) else $error("save while powered");
endmodule

// ==== dv/rmo_host.sv ====
// Fieldbus host model issuing one register request at a time.
`timescale 1ns/100ps
module rmo_host
  import rmo_pkg::*;
(
  input wire logic clk,
  output rmo_pkg::rmo_req_type req
);
  initial req = '0;
  task go(input logic w, input logic [1:0] s, input logic [11:0] d);
    @(posedge clk);
    #1;
    req = '{w, !w, s, d};
    @(posedge clk);
    #1;
    req = '{1'b0, 1'b0, ~s, ~d};
  endtask
endmodule

// ==== dv/rmo_remote_output_test.sv ====
// Self-checking bench for the remote output register block.
`timescale 1ns/100ps
module rmo_remote_output_test;
  import rmo_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, drive_reset = 1'b0, power_fail = 1'b0, write_protect = 1'b0;
  logic assigned_function_out = 1'b0, nvm_valid = 1'b0, nvm_save, general_output_terminal;
  logic [15:0] user_group_read_select = 16'h0;
  logic [11:0] nvm_data = 12'h000, nvm_save_data, v, w;
  logic [12:0] e, q[$];
  logic [3:0] pm = 4'h0, md[4] = '{MODE_CLR_CLR, MODE_KEEP_CLR, MODE_CLR_KEEP, MODE_KEEP_KEEP};
  rmo_req_type req;
  rmo_rsp_type rsp;
  int error_cnt = 0, checks = 0, seed = 47, n;
  always #5 clk = ~clk;
  rmo_host host_u (.clk(clk), .req(req));
  rmo_remote_output dut_u (.*);
  task chk(input logic [12:0] s, input logic [12:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task op(input logic wr, input logic [1:0] s, input logic [11:0] d, input logic [12:0] x);
    q.push_back(x);
    host_u.go(wr, s, d);
  endtask
  task trm(input logic x);
    @(posedge clk);
    #1;
    chk(13'(general_output_terminal), 13'(x));
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rsp.ack === 1'b1) begin
      e = q.pop_front();
      chk({rsp.err, e[12] ? 12'h000 : rsp.rdata}, e);
    end
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    op(1'b1, SEL_FSEL, 12'(FSEL_REM_POS), 13'h0);
    op(1'b1, SEL_DATA, 12'h0c1, 13'h0);
    trm(1'b1);
    op(1'b1, SEL_FSEL, 12'(FSEL_REM_NEG), 13'(FSEL_REM_POS));
    trm(1'b0);
    write_protect = 1'b1;
    op(1'b1, SEL_DATA, 12'hffe, 13'h0c1);
    trm(1'b1);
    write_protect = 1'b0;
    user_group_read_select = 16'h0001;
    op(1'b1, SEL_DATA, 12'h000, 13'h1000);
    user_group_read_select = 16'h0;
    op(1'b1, SEL_FSEL, 12'h000, 13'(FSEL_REM_NEG));
    assigned_function_out = 1'b1;
    op(1'b1, SEL_DATA, 12'h000, 13'hffe);
    repeat (2) @(posedge clk);
    trm(1'b1);
    $display("directed tests done");
    v = 12'h000;
    foreach (md[i]) begin
      w = 12'($random(seed));
      op(1'b1, SEL_MODE, 12'(md[i]), 13'(pm));
      op(1'b1, SEL_DATA, w, 13'(v));
      n = 0;
      power_fail = 1'b1;
      repeat (8) begin
        @(posedge clk);
        #1;
        n += int'(nvm_save === 1'b1);
        if (nvm_save === 1'b1) chk(13'(nvm_save_data), 13'(w));
      end
      power_fail = 1'b0;
      chk(13'(n), 13'(md[i][0]));
      drive_reset = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      drive_reset = 1'b0;
      v = md[i][3] ? w : 12'h000;
      pm = md[i];
      repeat (4) @(posedge clk);
      op(1'b0, SEL_DATA, 12'h000, 13'(v));
      $display("mode %h done", pm);
    end
    nvm_data = 12'h5a3;
    nvm_valid = 1'b1;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    op(1'b0, SEL_DATA, 12'h000, 13'h5a3);
    op(1'b0, SEL_MODE, 12'h000, 13'h0);
    $display("power cycle test done");
    repeat (2) @(posedge clk);
    chk(13'(q.size()), 13'h0);
    wrap_up;
  end
endmodule
bind rmo_remote_output rmo_remote_output_assertions chk_u (.*);
